// ---- design/nbcfg_addr_irq.sv ----
`timescale 1ns/1ps
module nbcfg_addr_irq (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic addr_byte_i,
	input wire logic addr_match_i,
	input wire logic type_sel_i,
	input wire logic enable_i,
	input wire logic clear_i,
	output logic event_o,
	output logic flag_o
);
	// ==================================================
	// address byte interrupt source
	logic flag_q;
	logic flag_d;
	wire logic any_hit = addr_byte_i & ~type_sel_i;
	wire logic match_hit = addr_byte_i & addr_match_i & type_sel_i;
	// disabled source raises nothing at all
	assign event_o = enable_i & (any_hit | match_hit);
	// new event beats a concurrent clear
	assign flag_d = event_o | (flag_q & ~clear_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_q <= 1'b0;
		else
			flag_q <= flag_d;
	end

	assign flag_o = flag_q;

	// ==================================================
	// checks
	flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		event_o |=> flag_q)
		else $error("flag not set after event");
	any_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(addr_byte_i && enable_i && !type_sel_i) |-> event_o)
		else $error("any address byte did not raise event");
	match_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(type_sel_i && !addr_match_i) |-> !event_o)
		else $error("unmatched address raised event");
	gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!enable_i |-> !event_o)
		else $error("event while disabled");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(flag_q && !clear_i) |=> flag_q)
		else $error("flag dropped without clear");
endmodule

// ---- design/nbcfg_pkg.sv ----
package nbcfg_pkg;

	// ==================================================
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_PORT_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_IO_BASE_HIGH = 8'h60;
	localparam logic [7:0] IDX_IO_BASE_LOW = 8'h61;
	localparam logic [7:0] IDX_IRQ_LINE_SELECT = 8'h70;
	localparam logic [7:0] IDX_ADDRESS_IRQ_CONTROL = 8'hf6;
	localparam logic [7:0] IDX_ADDRESS_IRQ_FLAG = 8'hf7;
	localparam logic [7:0] IDX_EXTENDED_PORT_CONTROL = 8'hf8;
	localparam logic [7:0] IDX_EVENT_STATUS = 8'h80;
	localparam logic [7:0] IDX_EVENT_MASK = 8'h81;

	// ==================================================
	// reset values
	localparam logic [7:0] RST_PORT_ACTIVATE = 8'h00;
	localparam logic [7:0] RST_IO_BASE_HIGH = 8'h02;
	localparam logic [7:0] RST_IO_BASE_LOW = 8'hf8;
	localparam logic [7:0] RST_IRQ_LINE_SELECT = 8'h03;
	localparam logic [7:0] RST_ADDRESS_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] RST_EXTENDED_PORT_CONTROL = 8'h00;
	localparam logic [7:0] RST_EVENT_MASK = 8'h00;

	// ==================================================
	// implemented bits, the rest read as zero
	localparam logic [7:0] MSK_PORT_ACTIVATE = 8'h01;
	localparam logic [7:0] MSK_IRQ_LINE_SELECT = 8'h0f;
	localparam logic [7:0] MSK_ADDRESS_IRQ_CONTROL = 8'h03;
	localparam logic [7:0] MSK_EXTENDED_PORT_CONTROL = 8'hdf;
	localparam logic [7:0] MSK_EVENTS = 8'h03;

	// ==================================================
	// field positions
	localparam int BIT_IRQ_ADDR_ENABLE = 0;
	localparam int BIT_IRQ_TYPE_SEL = 1;
	localparam int BIT_DEEP_FIFO_ENABLE = 0;
	localparam int BIT_PORT_SWAP_ENABLE = 4;
	localparam int BIT_LEVEL_RANGE_LO = 6;
	localparam int BIT_ALIGN = 3;
	localparam int EVT_NINE_BIT_IRQ = 0;
	localparam int EVT_ADDR_BYTE = 1;

	// rx trigger level in bytes, index {range, fifo_control_reg[7:6]}
	localparam logic [15:0][7:0] TRIG_LEVEL_LUT = {
		8'h7c, 8'h78, 8'h74, 8'h70, 8'h68, 8'h60, 8'h58, 8'h50,
		8'h40, 8'h30, 8'h20, 8'h10, 8'h0e, 8'h08, 8'h04, 8'h01};

	typedef struct packed {
		logic active;
		logic [15:0] io_base;
		logic [3:0] irq_line;
	} nbcfg_port_cfg_t;

	typedef struct packed {
		logic deep_fifo_enable;
		logic port_swap_enable;
		logic [7:0] trig_level;
	} nbcfg_fifo_cfg_t;

endpackage

// ---- design/nbcfg_regs.sv ----
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module nbcfg_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_addr_byte_i,
	input wire logic rx_addr_match_i,
	input wire logic [1:0] fifo_control_reg_i,
	input wire logic nine_bit_enable_i,
	input wire logic tx_addr_flag_i,
	input wire logic tx_parity_i,
	output logic tx_parity_bit_o,
	output logic nine_bit_irq_o,
	output logic irq_o,
	output nbcfg_pkg::nbcfg_fifo_cfg_t fifo_cfg_o,
	output nbcfg_pkg::nbcfg_port_cfg_t port_cfg_o
);
	// ==================================================
	// bus decode
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] activate_q;
	logic [7:0] base_hi_q;
	logic [7:0] base_lo_q;
	logic [7:0] line_q;
	logic [7:0] ctrl_q;
	logic [7:0] ext_q;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	logic [7:0] mask_q;
	logic irq_q;
	logic nb_irq_q;
	logic parity_q;
	nbcfg_pkg::nbcfg_fifo_cfg_t fifo_q;
	nbcfg_pkg::nbcfg_port_cfg_t port_q;

	wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic [7:0] idx = wb_adr_i[9:2];
	wire logic wr = req & wb_we_i & wb_sel_i[0];
	wire logic rd = req & ~wb_we_i;
	wire logic [7:0] wdat = wb_dat_i[7:0];
	wire logic hit_act = idx == nbcfg_pkg::IDX_PORT_ACTIVATE;
	wire logic hit_bhi = idx == nbcfg_pkg::IDX_IO_BASE_HIGH;
	wire logic hit_blo = idx == nbcfg_pkg::IDX_IO_BASE_LOW;
	wire logic hit_line = idx == nbcfg_pkg::IDX_IRQ_LINE_SELECT;
	wire logic hit_ctrl = idx == nbcfg_pkg::IDX_ADDRESS_IRQ_CONTROL;
	wire logic hit_flag = idx == nbcfg_pkg::IDX_ADDRESS_IRQ_FLAG;
	wire logic hit_ext = idx == nbcfg_pkg::IDX_EXTENDED_PORT_CONTROL;
	wire logic hit_stat = idx == nbcfg_pkg::IDX_EVENT_STATUS;
	wire logic hit_mask = idx == nbcfg_pkg::IDX_EVENT_MASK;

	// ==================================================
	// address interrupt source
	logic nb_event;
	logic nb_flag;
	// only a written 0 in bit 0 clears
	wire logic flag_clr = wr & hit_flag & ~wdat[0];

	nbcfg_addr_irq u_addr_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.addr_byte_i(rx_addr_byte_i),
		.addr_match_i(rx_addr_match_i),
		.type_sel_i(ctrl_q[nbcfg_pkg::BIT_IRQ_TYPE_SEL]),
		.enable_i(ctrl_q[nbcfg_pkg::BIT_IRQ_ADDR_ENABLE]),
		.clear_i(flag_clr),
		.event_o(nb_event),
		.flag_o(nb_flag)
	);

	// ==================================================
	// read mux, reserved bits read zero
	logic [7:0] rmux;
	always_comb
	begin
		rmux = 8'h00;
		if (hit_act)
			rmux = activate_q;
		else if (hit_bhi)
			rmux = base_hi_q;
		else if (hit_blo)
			rmux = base_lo_q;
		else if (hit_line)
			rmux = line_q;
		else if (hit_ctrl)
			rmux = ctrl_q;
		else if (hit_flag)
			rmux = {7'h00, nb_flag};
		else if (hit_ext)
			rmux = ext_q;
		else if (hit_stat)
			rmux = stat_q;
		else if (hit_mask)
			rmux = mask_q;
	end

	// ==================================================
	// event status, read clears but a new event wins
	wire logic [7:0] evt = {6'h00, rx_addr_byte_i, nb_event};
	assign stat_d = evt | (stat_q & ~{8{rd & hit_stat}});

	// ==================================================
	// registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			activate_q <= nbcfg_pkg::RST_PORT_ACTIVATE;
			base_hi_q <= nbcfg_pkg::RST_IO_BASE_HIGH;
			base_lo_q <= nbcfg_pkg::RST_IO_BASE_LOW;
			line_q <= nbcfg_pkg::RST_IRQ_LINE_SELECT;
			ctrl_q <= nbcfg_pkg::RST_ADDRESS_IRQ_CONTROL;
			ext_q <= nbcfg_pkg::RST_EXTENDED_PORT_CONTROL;
			mask_q <= nbcfg_pkg::RST_EVENT_MASK;
			stat_q <= 8'h00;
		end
		else
		begin
			if (wr && hit_act)
				activate_q <= wdat & nbcfg_pkg::MSK_PORT_ACTIVATE;
			if (wr && hit_bhi)
				base_hi_q <= wdat;
			if (wr && hit_blo)
				base_lo_q <= wdat;
			if (wr && hit_line)
				line_q <= wdat & nbcfg_pkg::MSK_IRQ_LINE_SELECT;
			if (wr && hit_ctrl)
				ctrl_q <= wdat & nbcfg_pkg::MSK_ADDRESS_IRQ_CONTROL;
			// bits 3..1 kept as written; software is to leave them zero
			if (wr && hit_ext)
				ext_q <= wdat & nbcfg_pkg::MSK_EXTENDED_PORT_CONTROL;
			if (wr && hit_mask)
				mask_q <= wdat & nbcfg_pkg::MSK_EVENTS;
			stat_q <= stat_d & nbcfg_pkg::MSK_EVENTS;
		end
	end

	// bus answer, one wait state, unmapped reads zero and writes drop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req;
			dat_q <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
		end
	end

	// ==================================================
	// outputs, all registered
	wire logic [15:0] base_aligned = {base_hi_q, base_lo_q[7:nbcfg_pkg::BIT_ALIGN], 3'h0};
	wire logic [3:0] range_sel = {ext_q[nbcfg_pkg::BIT_LEVEL_RANGE_LO +: 2], fifo_control_reg_i};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fifo_q <= '0;
			port_q <= '0;
			irq_q <= 1'b0;
			nb_irq_q <= 1'b0;
			parity_q <= 1'b0;
		end
		else
		begin
			fifo_q.trig_level <= nbcfg_pkg::TRIG_LEVEL_LUT[range_sel];
			fifo_q.deep_fifo_enable <= ext_q[nbcfg_pkg::BIT_DEEP_FIFO_ENABLE];
			fifo_q.port_swap_enable <= ext_q[nbcfg_pkg::BIT_PORT_SWAP_ENABLE];
			port_q.active <= activate_q[0];
			port_q.io_base <= base_aligned;
			port_q.irq_line <= line_q[3:0];
			irq_q <= |(stat_d & mask_q);
			// disabling the source also silences a flag already set
			nb_irq_q <= nb_flag & ctrl_q[nbcfg_pkg::BIT_IRQ_ADDR_ENABLE];
			parity_q <= nine_bit_enable_i ? tx_addr_flag_i : tx_parity_i;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign fifo_cfg_o = fifo_q;
	assign port_cfg_o = port_q;
	assign irq_o = irq_q;
	assign nine_bit_irq_o = nb_irq_q;
	assign tx_parity_bit_o = parity_q;

	// ==================================================
	// checks
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	trig_lut_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(ext_q[7:6] == 2'b01 && fifo_control_reg_i == 2'b10) |=> fifo_cfg_o.trig_level == 8'h30)
		else $error("trigger level wrong");
	deep_fifo_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_ext |=> ##1 fifo_cfg_o.deep_fifo_enable == $past(wdat[0], 2))
		else $error("deep fifo enable not following write");
	base_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
		port_cfg_o.io_base[2:0] == 3'h0)
		else $error("io base not aligned");
	active_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_act |=> ##1 port_cfg_o.active == $past(wdat[0], 2))
		else $error("activation not following write");
	reset_dflt_a: assert property (@(posedge clk_i)
		$past(rst_i) |-> base_hi_q == 8'h02 && base_lo_q == 8'hf8 && line_q == 8'h03)
		else $error("reset defaults wrong");
	parity_pos_a: assert property (@(posedge clk_i) disable iff (rst_i)
		nine_bit_enable_i |=> tx_parity_bit_o == $past(tx_addr_flag_i))
		else $error("parity position not carrying address flag");
	nb_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_q[0] |=> !nine_bit_irq_o)
		else $error("address interrupt not suppressed");
	flag_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && hit_flag |=> wb_dat_o[31:1] == 31'h0 && wb_dat_o[0] == $past(nb_flag))
		else $error("flag readback wrong");

	// ==================================================
	// bus answer checks
	ack_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !wb_ack_o)
		else $error("ack without request");
	// read data is zero outside ack so a sloppy master cannot latch stale bytes
	dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	dat_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read data not zero");

	// ==================================================
	// reserved bits and reset checks
	line_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		line_q[7:4] == 4'h0)
		else $error("line select reserved bits set");
	act_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		activate_q[7:1] == 7'h00)
		else $error("activation reserved bits set");
	ctrl_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_q[7:2] == 6'h00)
		else $error("control reserved bits set");
	ext_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ext_q[5])
		else $error("extended control bit 5 set");
	reset_out_a: assert property (@(posedge clk_i)
		rst_i |=> fifo_cfg_o == '0 && port_cfg_o == '0 && !irq_o && !nine_bit_irq_o
			&& !wb_ack_o && !tx_parity_bit_o)
		else $error("outputs not cleared by reset");
	// struct outputs lag the registers by one edge, so defaults show two edges on
	dflt_out_a: assert property (@(posedge clk_i)
		($past(rst_i) && !rst_i) |=> port_cfg_o.io_base == 16'h02f8 && port_cfg_o.irq_line == 4'h3
			&& !port_cfg_o.active)
		else $error("port defaults not shown after reset");

	// ==================================================
	// register follow checks
	swap_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_ext |=> ##1 fifo_cfg_o.port_swap_enable == $past(wdat[nbcfg_pkg::BIT_PORT_SWAP_ENABLE], 2))
		else $error("swap enable not following write");
	line_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_line |=> ##1 port_cfg_o.irq_line == $past(wdat[3:0], 2))
		else $error("irq line not following write");
	base_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && hit_bhi |=> ##1 port_cfg_o.io_base[15:8] == $past(wdat, 2))
		else $error("io base high not following write");

	// ==================================================
	// event and interrupt checks
	stat_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_addr_byte_i |=> stat_q[nbcfg_pkg::EVT_ADDR_BYTE])
		else $error("address byte not recorded");
	stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && hit_stat && !rx_addr_byte_i && !nb_event) |=> stat_q == 8'h00)
		else $error("status not cleared by read");
	stat_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(rd && hit_stat) |=> ($past(stat_q) & ~stat_q) == 8'h00)
		else $error("status bit lost without read");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(stat_q & $past(mask_q)))
		else $error("irq level wrong");
	flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(flag_clr && !nb_event) |=> !nb_flag)
		else $error("flag not cleared by written zero");
	// a one-edge reset leaves the sampled flag stale, so skip the edge after it
	nb_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> nine_bit_irq_o == ($past(nb_flag) && $past(ctrl_q[0])))
		else $error("address interrupt output wrong");

	cov_any_c: cover property (@(posedge clk_i) nb_event && !ctrl_q[1]);
	cov_match_c: cover property (@(posedge clk_i) nb_event && ctrl_q[1]);
	cov_clear_c: cover property (@(posedge clk_i) flag_clr && nb_flag);
	cov_irq_c: cover property (@(posedge clk_i) irq_o);
	cov_stat_clr_c: cover property (@(posedge clk_i) rd && hit_stat && stat_q != 8'h00);
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
	logic [3:0] sel = 4'h0;
	logic ack, tpb, nbirq, irq;
	logic abyte = 1'b0, amatch = 1'b0, nben = 1'b0, taf = 1'b0, tpar = 1'b0;
	logic [1:0] fcr = 2'h0;
	nbcfg_pkg::nbcfg_fifo_cfg_t fcfg;
	nbcfg_pkg::nbcfg_port_cfg_t pcfg;
	int err_total = 0;
	int check_count = 0;
	logic [7:0] q;
	logic [24:0] rows [0:16];
	// rx trigger level in bytes, index {range, fifo control}
	logic [7:0] lvl [0:15] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h10, 8'h20, 8'h30, 8'h40,
		8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7c};

	nbcfg_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rx_addr_byte_i(abyte), .rx_addr_match_i(amatch), .fifo_control_reg_i(fcr),
		.nine_bit_enable_i(nben), .tx_addr_flag_i(taf), .tx_parity_i(tpar), .tx_parity_bit_o(tpb),
		.nine_bit_irq_o(nbirq), .irq_o(irq), .fifo_cfg_o(fcfg), .port_cfg_o(pcfg));

	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	// ==================================================
	// bus and event helpers
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {22'h0, idx, 2'h0};
		wdat <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
			err_total++;
	endtask

	task automatic pulse(input logic m);
		@(posedge clk_i);
		abyte <= 1'b1;
		amatch <= m;
		@(posedge clk_i);
		abyte <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_total++;
		close_out();
	end

	// ==================================================
	// main sequence
	initial
	begin
		rows = '{{1'b0, 8'h30, 8'h00, 8'h00}, {1'b0, 8'h60, 8'h00, 8'h02}, {1'b0, 8'h61, 8'h00, 8'hf8},
			{1'b0, 8'h70, 8'h00, 8'h03}, {1'b0, 8'hf6, 8'h00, 8'h00}, {1'b0, 8'hf7, 8'h00, 8'h00},
			{1'b0, 8'hf8, 8'h00, 8'h00}, {1'b0, 8'h81, 8'h00, 8'h00}, {1'b1, 8'h30, 8'hff, 8'h01},
			{1'b1, 8'h60, 8'h12, 8'h12}, {1'b1, 8'h61, 8'hff, 8'hff}, {1'b1, 8'h70, 8'hff, 8'h0f},
			{1'b1, 8'hf6, 8'hff, 8'h03}, {1'b1, 8'hf7, 8'hff, 8'h00}, {1'b1, 8'hf8, 8'hf1, 8'hd1},
			{1'b1, 8'h55, 8'haa, 8'h00}, {1'b1, 8'hf6, 8'h00, 8'h00}};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i][24])
				bus(1'b1, rows[i][23:16], rows[i][15:8], q);
			bus(1'b0, rows[i][23:16], 8'h00, q);
			`CHK("reg", rows[i][7:0], q)
		end
		`CHK("io_base", 16'h12f8, pcfg.io_base)
		`CHK("irq_line", 4'hf, pcfg.irq_line)
		`CHK("active", 1'b1, pcfg.active)
		`CHK("swap", 1'b1, fcfg.port_swap_enable)
		for (int i = 0; i < 16; i++)
		begin
			bus(1'b1, 8'hf8, {i[3:2], 6'h01}, q);
			fcr <= i[1:0];
			repeat (2) @(posedge clk_i);
			`CHK("trig", lvl[i], fcfg.trig_level)
			`CHK("deep", 1'b1, fcfg.deep_fifo_enable)
		end
		bus(1'b1, 8'hf8, 8'h00, q);
		repeat (2) @(posedge clk_i);
		`CHK("deep off", 1'b0, fcfg.deep_fifo_enable)
		// ==================================================
		// address interrupt, type any then matched only
		bus(1'b0, 8'h80, 8'h00, q);
		bus(1'b1, 8'h81, 8'h00, q);
		bus(1'b1, 8'hf6, 8'h01, q);
		pulse(1'b0);
		bus(1'b0, 8'hf7, 8'h00, q);
		`CHK("flag any", 8'h01, q)
		`CHK("nb irq", 1'b1, nbirq)
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, 8'h81, 8'h03, q);
		@(posedge clk_i);
		`CHK("irq unmasked", 1'b1, irq)
		bus(1'b0, 8'h80, 8'h00, q);
		`CHK("status", 8'h03, q)
		@(posedge clk_i);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b1, 8'hf7, 8'h01, q);
		bus(1'b0, 8'hf7, 8'h00, q);
		`CHK("flag w1", 8'h01, q)
		bus(1'b1, 8'hf6, 8'h00, q);
		@(posedge clk_i);
		`CHK("nb gated", 1'b0, nbirq)
		bus(1'b1, 8'hf7, 8'h00, q);
		bus(1'b1, 8'hf6, 8'h03, q);
		pulse(1'b0);
		bus(1'b0, 8'hf7, 8'h00, q);
		`CHK("flag nomatch", 8'h00, q)
		pulse(1'b1);
		bus(1'b0, 8'hf7, 8'h00, q);
		`CHK("flag match", 8'h01, q)
		// ==================================================
		// parity slot and mid-run reset
		nben <= 1'b1;
		taf <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK("par addr", 1'b1, tpb)
		nben <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK("par norm", 1'b0, tpb)
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK("rst port", 21'h002f83, pcfg)
		`CHK("rst nb irq", 1'b0, nbirq)
		close_out();
	end
endmodule
